// ### rtl/ssp_cfg.svh
// constants of the serial sram pause port
// What this block does
// R1: status write loads mode; reserved bits zero
// R2: power-up standby until chip select falls
// R3: select low selects, high forces standby
// R4: output released while deselected
// R5: input captured on rising serial clock
// R6: output changes only after falling clock
// R7: host keeps pause high when unused
// R8: pause suspends sequence, keeps its state
// R9: pause taken while clock low, else next fall
// R10: host keeps select low while paused
// R11: paused device ignores clock and input
// R12: resume only when raised with clock low
// R13: pause low releases the output unless the disable bit is set
// R14: pause ignored when disable bit set
// R15: status write 01h, read 05h, msb first
// R16: bits 7:6 select byte, page, sequential mode
// R17: bit0 pause disable, bit1 reads one
// R18: select high clears partial instruction
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_INSTR_STAT_WR 8'h01
`define SSP_INSTR_STAT_RD 8'h05
`define SSP_INSTR_READ 8'h03
`define SSP_INSTR_WRITE 8'h02
`define SSP_STAT_MODE_HI 7
`define SSP_STAT_MODE_LO 6
`define SSP_STAT_ONE_BIT 1
`define SSP_STAT_PDIS_BIT 0
`define SSP_MODE_RST 2'h0
`define SSP_PDIS_RST 1'b0
`define SSP_MODE_BYTE 2'h0
`define SSP_MODE_PAGE 2'h2
`define SSP_MODE_SEQ 2'h1
`define SSP_ARRAY_MSB 12
`define SSP_PAGE_MSB 4
`define SSP_CLK_NS 4
`define SSP_SCK_NS 64
`define SSP_SCK_HALF (`SSP_SCK_NS / (2 * `SSP_CLK_NS))
`endif

// ### rtl/ssp_pkg.sv
// types shared by both ends of the serial sram pause port
package ssp_pkg;
  typedef logic [1:0] ssp_mode_t;
  typedef enum logic [2:0] {
    DS_CMD, DS_ADDR, DS_WDATA, DS_RDATA, DS_STWR, DS_STRD, DS_IGNORE
  } ssp_dev_state_e;
  typedef enum logic [2:0] {
    HS_IDLE, HS_SEL, HS_SHIFT, HS_HOLD, HS_DESEL
  } ssp_host_state_e;
endpackage

// ### rtl/ssp_link_if.sv
// serial link between host controller and memory front end
`timescale 1ns/1ps
interface ssp_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe;
  logic so_line;
  // released line reads as pulled high
  assign so_line = so_oe ? so : 1'b1;
  modport dev (input sck, input cs_n, input si, input hold_n, output so, output so_oe);
  modport host (output sck, output cs_n, output si, output hold_n, input so_line);
endinterface

// ### rtl/ssp_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module ssp_sync2 (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_q;
  logic meta_d;
  logic q_d;
  always_comb begin
    meta_d = d_in;
    q_d = meta_q;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= 1'b1;
      q_out <= 1'b1;
    end else begin
      meta_q <= meta_d;
      q_out <= q_d;
    end
  end
endmodule

// ### rtl/ssp_dev.sv
// memory end of the serial link, clocked by the serial clock
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_dev (
  ssp_link_if.dev link,
  input wire logic resetn_in,
  input wire logic [7:0] rd_data_in,
  output logic [15:0] mem_addr_out,
  output logic rd_act_out,
  output logic wr_stb_out,
  output logic [7:0] wr_data_out,
  output ssp_pkg::ssp_mode_t mode_out,
  output logic pause_dis_out,
  output logic paused_out
);
  import ssp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address step per operating mode
  function automatic logic [15:0] ssp_next_addr(input logic [15:0] a, input ssp_mode_t m);
    logic [15:0] r;
    r = a;
    case (m)
      `SSP_MODE_PAGE: begin
        r[`SSP_PAGE_MSB:0] = (`SSP_PAGE_MSB + 1)'(a[`SSP_PAGE_MSB:0] + 1'b1); // [R16]
      end
      `SSP_MODE_SEQ: begin
        r = 16'h0000;
        r[`SSP_ARRAY_MSB:0] = (`SSP_ARRAY_MSB + 1)'(a[`SSP_ARRAY_MSB:0] + 1'b1); // [R16]
      end
      default: r = a;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // resets: power-on, and chip select high for the sequence
  logic seq_rst_n;
  logic pause_set;
  logic pause_clr_n;
  logic hold_en;
  logic hold_low;
  assign seq_rst_n = resetn_in & ~link.cs_n; // [R2] [R3] [R18]
  assign hold_en = ~pause_dis_out; // [R14]
  assign hold_low = hold_en & ~link.hold_n;
  // pause is taken or left only while the serial clock is low, except that chip select high clears it at once
  assign pause_set = hold_low & ~link.sck; // [R9]
  assign pause_clr_n = seq_rst_n & (hold_low | link.sck); // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // rising-edge sequence state
  ssp_dev_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [15:0] addr_d;
  logic rd_act_d;
  logic wr_stb_d;
  logic [7:0] wr_data_d;
  logic stat_wr;
  logic [7:0] stat_wdata;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = mem_addr_out;
    rd_act_d = rd_act_out;
    wr_stb_d = 1'b0;
    wr_data_d = wr_data_out;
    stat_wr = 1'b0;
    stat_wdata = sh_q;
    // a rising edge with pause held low and not disabled changes nothing but the write strobe, which drops
    if (!hold_low) begin // [R8] [R9] [R11] [R12]
      sh_d = {sh_q[6:0], link.si}; // [R5] [R15]
      cnt_d = 4'(cnt_q + 4'h1);
      case (st_q)
        DS_CMD: begin
          if (cnt_q == 4'h7) begin
            cnt_d = 4'h0;
            case (sh_d)
              `SSP_INSTR_STAT_WR: st_d = DS_STWR; // [R15]
              `SSP_INSTR_STAT_RD: st_d = DS_STRD; // [R15]
              `SSP_INSTR_READ: begin
                st_d = DS_ADDR;
                rd_act_d = 1'b1;
              end
              `SSP_INSTR_WRITE: begin
                st_d = DS_ADDR;
                rd_act_d = 1'b0;
              end
              default: st_d = DS_IGNORE;
            endcase
          end
        end
        DS_ADDR: begin
          addr_d = {mem_addr_out[14:0], link.si};
          if (cnt_q == 4'hf) begin
            addr_d[15:`SSP_ARRAY_MSB + 1] = '0;
            cnt_d = 4'h0;
            st_d = rd_act_out ? DS_RDATA : DS_WDATA;
          end
        end
        DS_WDATA: begin
          if (cnt_q == 4'h7) begin
            cnt_d = 4'h0;
            wr_stb_d = 1'b1;
            wr_data_d = sh_d;
            addr_d = ssp_next_addr(mem_addr_out, mode_out);
            if (mode_out == `SSP_MODE_BYTE) begin // [R16]
              st_d = DS_IGNORE;
            end
          end
        end
        DS_RDATA: begin
          if (cnt_q == 4'h7) begin
            cnt_d = 4'h0;
            addr_d = ssp_next_addr(mem_addr_out, mode_out);
            if (mode_out == `SSP_MODE_BYTE) begin // [R16]
              st_d = DS_IGNORE;
              rd_act_d = 1'b0;
            end
          end
        end
        DS_STWR: begin
          if (cnt_q == 4'h7) begin
            cnt_d = 4'h0;
            stat_wr = 1'b1; // [R1]
            stat_wdata = sh_d;
            st_d = DS_IGNORE;
          end
        end
        DS_STRD: begin
          if (cnt_q == 4'h7) begin
            cnt_d = 4'h0;
          end
        end
        DS_IGNORE: cnt_d = 4'h0;
        default: st_d = DS_IGNORE;
      endcase
    end
  end

  always_ff @(posedge link.sck or negedge seq_rst_n) begin
    if (!seq_rst_n) begin // [R18]
      st_q <= DS_CMD;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      mem_addr_out <= 16'h0000;
      rd_act_out <= 1'b0;
      wr_stb_out <= 1'b0;
      wr_data_out <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      mem_addr_out <= addr_d;
      rd_act_out <= rd_act_d;
      wr_stb_out <= wr_stb_d;
      wr_data_out <= wr_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register, kept across deselection
  ssp_mode_t mode_d;
  logic pdis_d;
  logic [7:0] stat_rdata;

  always_comb begin
    mode_d = mode_out;
    pdis_d = pause_dis_out;
    if (stat_wr) begin
      mode_d = stat_wdata[`SSP_STAT_MODE_HI:`SSP_STAT_MODE_LO]; // [R1] [R16]
      pdis_d = stat_wdata[`SSP_STAT_PDIS_BIT]; // [R17]
    end
    stat_rdata = 8'h00;
    stat_rdata[`SSP_STAT_MODE_HI:`SSP_STAT_MODE_LO] = mode_out;
    stat_rdata[`SSP_STAT_ONE_BIT] = 1'b1; // [R17]
    stat_rdata[`SSP_STAT_PDIS_BIT] = pause_dis_out;
  end

  always_ff @(posedge link.sck or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_out <= `SSP_MODE_RST;
      pause_dis_out <= `SSP_PDIS_RST;
    end else begin
      mode_out <= mode_d;
      pause_dis_out <= pdis_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling-edge output shifter and pause flag
  logic [7:0] osh_q, osh_d;
  logic so_q, so_d;
  logic paused_d;
  logic out_phase;
  assign out_phase = (st_q == DS_RDATA) || (st_q == DS_STRD);

  always_comb begin
    osh_d = osh_q;
    so_d = so_q;
    paused_d = hold_low; // [R9]
    if (!hold_low && out_phase) begin // [R8] [R11]
      if (cnt_q == 4'h0) begin
        osh_d = (st_q == DS_STRD) ? stat_rdata : rd_data_in;
        so_d = osh_d[7]; // [R6] [R15]
      end else begin
        osh_d = {osh_q[6:0], 1'b0};
        so_d = osh_q[6]; // [R6]
      end
    end
  end

  always_ff @(negedge link.sck or negedge seq_rst_n) begin
    if (!seq_rst_n) begin
      osh_q <= 8'h00;
      so_q <= 1'b0;
    end else begin
      osh_q <= osh_d;
      so_q <= so_d;
    end
  end

  // with pause enabled, the flag follows the pin while the clock is low and holds while it is high
  always_ff @(negedge link.sck or negedge pause_clr_n or posedge pause_set) begin
    if (!pause_clr_n) begin // [R12]
      paused_out <= 1'b0;
    end else if (pause_set) begin // [R8] [R9]
      paused_out <= 1'b1;
    end else begin
      paused_out <= paused_d;
    end
  end

  // enable kept through a pause so the held bit is driven again on resume
  logic oe_q, oe_d;
  always_comb begin
    oe_d = out_phase;
  end

  always_ff @(negedge link.sck or negedge seq_rst_n) begin
    if (!seq_rst_n) begin // [R4]
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign link.so = so_q;
  assign link.so_oe = oe_q & ~hold_low & ~paused_out; // [R11] [R13]
endmodule

// ### rtl/ssp_host.sv
// host controller end: divides its clock into the serial clock
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_host #(
  parameter int HALF = `SSP_SCK_HALF
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  ssp_link_if.host link,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_data_in,
  output logic req_ready_out,
  input wire logic pause_req_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out
);
  import ssp_pkg::*;
  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

  logic so_s;
  ssp_sync2 u_so_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(link.so_line),
    .q_out(so_s)
  );

  ssp_host_state_e st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] tx_q, tx_d;
  logic [7:0] rx_d;
  logic sck_q, sck_d;
  logic cs_n_q, cs_n_d;
  logic hold_n_q, hold_n_d;
  logic ready_d;
  logic rsp_valid_d;
  logic div_end;
  assign div_end = (div_q == HALF_LAST);

  always_comb begin
    st_d = st_q;
    div_d = div_end ? 8'h00 : 8'(div_q + 8'h01);
    cnt_d = cnt_q;
    tx_d = tx_q;
    rx_d = rsp_data_out;
    sck_d = sck_q;
    cs_n_d = cs_n_q;
    hold_n_d = hold_n_q;
    ready_d = req_ready_out;
    rsp_valid_d = 1'b0;
    case (st_q)
      HS_IDLE: begin
        div_d = 8'h00;
        if (req_valid_in && req_ready_out) begin
          ready_d = 1'b0;
          cs_n_d = 1'b0; // [R2] [R3]
          cnt_d = 4'h0;
          if (req_write_in) begin
            tx_d = {`SSP_INSTR_STAT_WR, 8'h00}; // [R15]
            tx_d[`SSP_STAT_MODE_HI:`SSP_STAT_MODE_LO] =
              req_data_in[`SSP_STAT_MODE_HI:`SSP_STAT_MODE_LO]; // [R1] [R16]
            tx_d[`SSP_STAT_PDIS_BIT] = req_data_in[`SSP_STAT_PDIS_BIT]; // [R1] [R17]
          end else begin
            tx_d = {`SSP_INSTR_STAT_RD, 8'h00}; // [R15]
          end
          st_d = HS_SEL;
        end
      end
      HS_SEL: begin
        if (div_end) begin
          st_d = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        if (div_end) begin
          if (!sck_q) begin
            if (pause_req_in) begin
              hold_n_d = 1'b0; // [R9] [R10]
              st_d = HS_HOLD;
            end else begin
              sck_d = 1'b1;
              rx_d = {rsp_data_out[6:0], so_s}; // [R5]
            end
          end else begin
            sck_d = 1'b0;
            if (cnt_q == 4'hf) begin
              st_d = HS_DESEL;
            end else begin
              cnt_d = 4'(cnt_q + 4'h1);
              tx_d = {tx_q[14:0], 1'b0}; // [R6] [R15]
            end
          end
        end
      end
      HS_HOLD: begin
        div_d = 8'h00;
        if (!pause_req_in) begin
          hold_n_d = 1'b1; // [R7] [R12]
          st_d = HS_SHIFT;
        end
      end
      HS_DESEL: begin
        if (div_end) begin
          if (!cs_n_q) begin
            cs_n_d = 1'b1; // [R18]
          end else begin
            rsp_valid_d = 1'b1;
            ready_d = 1'b1;
            st_d = HS_IDLE;
          end
        end
      end
      default: st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= HS_IDLE;
      div_q <= 8'h00;
      cnt_q <= 4'h0;
      tx_q <= 16'h0000;
      rsp_data_out <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      hold_n_q <= 1'b1;
      req_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      rsp_data_out <= rx_d;
      sck_q <= sck_d;
      cs_n_q <= cs_n_d;
      hold_n_q <= hold_n_d;
      req_ready_out <= ready_d;
      rsp_valid_out <= rsp_valid_d;
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.si = tx_q[15];
  assign link.hold_n = hold_n_q;
endmodule

// ### testbench/ssp_link_properties.sv
// concurrent checks on the serial link between host and memory ends
`timescale 1ns/1ps
module ssp_link_properties (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic pause_dis_out,
  input wire logic paused_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_desel_release; cs_n |-> !so_oe; endproperty
  a_desel_release: assert property (p_desel_release) else $error("so driven while deselected");
  property p_hold_release; !hold_n && !pause_dis_out |-> !so_oe; endproperty
  a_hold_release: assert property (p_hold_release) else $error("so driven with pause low");
  property p_paused_quiet; paused_out |-> !so_oe; endproperty
  a_paused_quiet: assert property (p_paused_quiet) else $error("so driven while paused");
  property p_pause_taken; $rose(paused_out) |-> !hold_n && !sck && !pause_dis_out; endproperty
  a_pause_taken: assert property (p_pause_taken) else $error("pause taken wrongly");
  property p_paused_sel; paused_out |-> !cs_n; endproperty
  a_paused_sel: assert property (p_paused_sel) else $error("deselected while paused");
  property p_hold_fall; $fell(hold_n) |-> !sck; endproperty
  a_hold_fall: assert property (p_hold_fall) else $error("pause lowered with clock high");
  property p_hold_rise; $rose(hold_n) |-> !sck; endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("pause raised with clock high");
  property p_resume; $past(paused_out) && $rose(hold_n) |-> ##[1:20] !paused_out; endproperty
  a_resume: assert property (p_resume) else $error("no resume after pause release");
  property p_so_fall; so_oe && $past(so_oe) && $changed(so) |-> !sck; endproperty
  a_so_fall: assert property (p_so_fall) else $error("so changed with clock high");
  property p_oe_fall; $rose(so_oe) |-> !sck && !cs_n; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("so enabled off falling edge");
  property p_idle_clk; cs_n && $past(cs_n) |-> !sck; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("serial clock not idle low");
endmodule

// ### testbench/tb_top.sv
// self-checking bench joining host and memory ends
`timescale 1ns/1ps
module tb_top;
  import ssp_pkg::*;
  logic clk_in, resetn_in, req_valid_in, req_write_in, pause_req_in, req_ready_out;
  logic rsp_valid_out, pause_dis_out, paused_out, pdis_m, saw_pause;
  logic [7:0] req_data_in, rd_data_in, rsp_data_out;
  logic [15:0] lfsr_q, sh;
  ssp_mode_t mode_out, mode_m;
  int miscompares, checked;
  ssp_link_if ssp_link_if_inst ();
  ssp_host #(.HALF(8)) ssp_host_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .link(ssp_link_if_inst.host), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_data_in(req_data_in), .req_ready_out(req_ready_out), .pause_req_in(pause_req_in),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out));
  ssp_dev ssp_dev_inst (.link(ssp_link_if_inst.dev), .resetn_in(resetn_in),
    .rd_data_in(rd_data_in), .mem_addr_out(), .rd_act_out(), .wr_stb_out(), .wr_data_out(),
    .mode_out(mode_out), .pause_dis_out(pause_dis_out), .paused_out(paused_out));
  ssp_link_properties chk_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .sck(ssp_link_if_inst.sck), .cs_n(ssp_link_if_inst.cs_n), .hold_n(ssp_link_if_inst.hold_n),
    .so(ssp_link_if_inst.so), .so_oe(ssp_link_if_inst.so_oe), .pause_dis_out(pause_dis_out),
    .paused_out(paused_out));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // wire-side capture of every bit the memory end samples
  always @(posedge ssp_link_if_inst.sck)
    if (!ssp_link_if_inst.cs_n) sh = {sh[14:0], ssp_link_if_inst.si};
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic standby();
    check("desel", 8'h02, {6'h0, ssp_link_if_inst.cs_n, ssp_link_if_inst.so_oe});
    check("mode", {6'h0, mode_m}, {6'h0, mode_out});
    check("pdis", {7'h0, pdis_m}, {7'h0, pause_dis_out});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one request; pa is the cycle at which a pause is asked for, -1 for none
  task automatic xfer(input logic wr, input logic [7:0] d, input int pa);
    int i;
    saw_pause = 1'b0;
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_data_in <= d;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (req_ready_out !== 1'b1 && i < 50);
    if (req_ready_out !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    req_valid_in <= 1'b0;
    for (i = 0; i < 3000 && rsp_valid_out !== 1'b1; i++) begin
      @(posedge clk_in);
      if (i == pa) pause_req_in <= 1'b1;
      if (i == pa + 80) pause_req_in <= 1'b0;
      if (paused_out === 1'b1) saw_pause = 1'b1;
    end
    pause_req_in <= 1'b0;
    if (i >= 3000) begin
      miscompares++;
      wrap_up();
    end
    check("paused", {7'h0, pa >= 0 && !pdis_m}, {7'h0, saw_pause});
    check("instr", wr ? 8'h01 : 8'h05, sh[15:8]);
    if (wr) begin
      check("wdata", {d[7:6], 5'h00, d[0]}, sh[7:0]);
      mode_m = d[7:6];
      pdis_m = d[0];
    end else begin
      check("status", {mode_m, 5'h01, pdis_m}, rsp_data_out);
    end
    repeat (20) @(posedge clk_in);
    standby();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_data_in = 8'h00;
    pause_req_in = 1'b0;
    rd_data_in = 8'h00;
    lfsr_q = 16'hf28f;
    miscompares = 0;
    checked = 0;
    mode_m = 2'h0;
    pdis_m = 1'b0;
    sh = 16'h0000;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    standby();
    xfer(1'b0, 8'h00, -1);
    for (int k = 0; k < 8; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      rd_data_in <= lfsr_q[15:8];
      xfer(1'b1, {2'(k % 3), lfsr_q[5:1], k[1]}, k[0] ? 100 : -1);
      xfer(1'b0, 8'h00, 100);
    end
    // reset in mid-sequence must drop the partial write
    req_valid_in <= 1'b1;
    req_write_in <= 1'b1;
    req_data_in <= 8'h41;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    repeat (100) @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    mode_m = 2'h0;
    pdis_m = 1'b0;
    @(posedge clk_in);
    standby();
    xfer(1'b0, 8'h00, 100);
    wrap_up();
  end
endmodule
